/* File: hdl/mmne_exec.sv */
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// - store_accumulator copies the accumulator into the addressed file byte, flags untouched.
// - bank bit 0 selects the access bank, bank bit 1 the bank chosen by bank_select_register.
// - bank bit 0, extended set on and operand at most 95 gives indexed literal offset mode.
// - multiply_literal writes accumulator times literal, high byte to product_high.
// - both multiplies leave flags and accumulator unchanged and flag nothing.
// - multiply_file stores accumulator times file byte in the product pair, sources kept.
// - negate_file writes the two's complement of the file byte back to the same byte.
// - negate_file updates N, signed_range_exceeded, C, half_carry and Z; others touch none.
// - the 8-bit operand reaches any byte of the addressed 256-byte bank, except access bank offsets 0 to 95 in indexed mode.
module mmne_exec
  import mmne_pkg::*;
#(
  parameter int MEM_DEPTH = 4096
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             busy_o
);

  // depth must cover one bank and fit the address width
  if (MEM_DEPTH < 256 || MEM_DEPTH > (1 << MEM_AW)) begin : g_bad_depth
    $error("mmne_exec: MEM_DEPTH out of range");
  end

  mmne_state_t       st;
  mmne_state_t       next_st;
  mmne_mem_wr_t      mem_wr;
  logic [MEM_AW-1:0] mem_raddr;
  logic [7:0]        mem_rdata;
  logic              bus_take;

  //////////////////////////////////////////////////////////////////////////////
  // instruction decode
  function automatic mmne_op_t decode_op(input logic [15:0] w);
    mmne_op_t op;
    op = OP_IDLE;
    if (w[15:9] == OPC_STORE) begin
      op = OP_STORE;
    end else if (w[15:9] == OPC_NEGATE) begin
      op = OP_NEGATE;
    end else if (w[15:8] == OPC_MUL_LIT) begin
      op = OP_MUL_LIT;
    end else if (w[15:9] == OPC_MUL_FILE) begin
      op = OP_MUL_FILE;
    end else if (w == OPC_IDLE || w[15:12] == OPC_IDLE_HI) begin
      op = OP_IDLE;
    end
    return op;
  endfunction : decode_op

  // effective data address of the file operand
  function automatic logic [MEM_AW-1:0] eff_addr(input logic [15:0]       w,
                                                 input logic [3:0]        bank,
                                                 input logic              ext,
                                                 input logic [MEM_AW-1:0] base);
    logic [MEM_AW-1:0] a;
    a = {ACCESS_LO, w[7:0]};
    if (w[8]) begin
      a = {bank, w[7:0]};
    end else if (ext && w[7:0] <= INDEX_LIMIT) begin
      a = MEM_AW'(base + {ACCESS_LO, w[7:0]});
    end else if (w[7:0] >= ACCESS_SPLIT) begin
      a = {ACCESS_HI, w[7:0]};
    end
    return a;
  endfunction : eff_addr

  //////////////////////////////////////////////////////////////////////////////
  // file byte storage
  mmne_data_mem #(
    .DEPTH (MEM_DEPTH)
  ) u_mem (
    .clk_i   (clk_i),
    .wr_i    (mem_wr),
    .raddr_i (mem_raddr),
    .rdata_o (mem_rdata)
  );

  // bus reaches memory only while idle
  assign mem_raddr = (st.phase == PH_IDLE) ? st.mem_addr : st.ea;
  assign bus_take  = wb_cyc_i && wb_stb_i && !st.ack && st.phase == PH_IDLE;

  //////////////////////////////////////////////////////////////////////////////
  // next state: bus slave and four execution phases
  always_comb begin
    next_st     = st;
    next_st.ack = 1'b0;
    mem_wr      = '0;
    if (bus_take) begin
      next_st.ack = 1'b1;
      case (wb_adr_i)
        REG_INSTR:    next_st.dat = {16'h0000, st.instr};
        REG_ACCUM:    next_st.dat = {24'h000000, st.wreg};
        REG_BANKSEL:  next_st.dat = {28'h0000000, st.bank_select_register};
        REG_PROD_LO:  next_st.dat = {24'h000000, st.product_low_byte};
        REG_PROD_HI:  next_st.dat = {24'h000000, st.product_high};
        REG_STATUS:   next_st.dat = {27'h0000000, st.status};
        REG_CTRL:     next_st.dat = {31'h00000000, st.ext_en};
        REG_IDX_BASE: next_st.dat = {20'h00000, st.idx_base};
        REG_MEM_ADDR: next_st.dat = {20'h00000, st.mem_addr};
        REG_MEM_DATA: next_st.dat = {24'h000000, mem_rdata};
        default:      next_st.dat = 32'h00000000;
      endcase
      if (wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          REG_INSTR: begin
            next_st.instr = wb_dat_i[15:0];
            next_st.phase = PH_DECODE;
          end
          REG_ACCUM:    next_st.wreg     = wb_dat_i[7:0];
          REG_BANKSEL:  next_st.bank_select_register      = wb_dat_i[3:0];
          REG_PROD_LO:  next_st.product_low_byte    = wb_dat_i[7:0];
          REG_PROD_HI:  next_st.product_high    = wb_dat_i[7:0];
          REG_STATUS:   next_st.status   = wb_dat_i[4:0];
          REG_CTRL:     next_st.ext_en   = wb_dat_i[CTRL_EXT];
          REG_IDX_BASE: next_st.idx_base = wb_dat_i[MEM_AW-1:0];
          REG_MEM_ADDR: next_st.mem_addr = wb_dat_i[MEM_AW-1:0];
          REG_MEM_DATA: begin
            mem_wr.we   = 1'b1;
            mem_wr.addr = st.mem_addr;
            mem_wr.data = wb_dat_i[7:0];
          end
          default: ;
        endcase
      end
    end
    case (st.phase)
      PH_IDLE: ;
      PH_DECODE: begin
        next_st.op    = decode_op(st.instr);
        next_st.ea    = eff_addr(st.instr, st.bank_select_register, st.ext_en, st.idx_base);
        next_st.phase = PH_READ;
      end
      PH_READ: begin
        next_st.opnd  = (st.op == OP_MUL_LIT) ? st.instr[7:0] : mem_rdata;
        next_st.phase = PH_PROC;
      end
      PH_PROC: begin
        case (st.op)
          OP_STORE:    next_st.result = {8'h00, st.wreg};
          OP_MUL_LIT,
          OP_MUL_FILE: next_st.result = 16'(st.wreg) * 16'(st.opnd);
          OP_NEGATE: begin
            next_st.result              = {8'h00, 8'(~st.opnd + 8'h01)};
            next_st.nflags[FLG_C]       = (st.opnd == 8'h00);
            next_st.nflags[FLG_HC]      = (st.opnd[3:0] == 4'h0);
            next_st.nflags[FLG_Z]       = (st.opnd == 8'h00);
            next_st.nflags[FLG_OV]      = (st.opnd == 8'h80);
            next_st.nflags[FLG_N]       = next_st.result[7];
          end
          default: ;
        endcase
        next_st.phase = PH_WRITE;
      end
      PH_WRITE: begin
        case (st.op)
          OP_STORE, OP_NEGATE: begin
            mem_wr.we   = 1'b1;
            mem_wr.addr = st.ea;
            mem_wr.data = st.result[7:0];
          end
          default: ;
        endcase
        if (st.op == OP_NEGATE) begin
          next_st.status = st.nflags;
        end
        if (st.op == OP_MUL_LIT || st.op == OP_MUL_FILE) begin
          next_st.product_high = st.result[15:8];
          next_st.product_low_byte = st.result[7:0];
        end
        next_st.phase = PH_IDLE;
      end
      default: next_st.phase = PH_IDLE;
    endcase
    next_st.busy = (next_st.phase != PH_IDLE);
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st        <= '0;
      st.status <= STATUS_RST;
      st.bank_select_register    <= BANKSEL_RST;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;
  assign busy_o   = st.busy;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  chk_store_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.phase == PH_WRITE && st.op == OP_STORE) |->
      (mem_wr.we && mem_wr.data == st.wreg && mem_wr.addr == st.ea) ##1 $stable(st.status))
    else $error("store did not copy accumulator");

  chk_bank_pick: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.phase == PH_READ && st.op != OP_MUL_LIT && st.instr[8]) |->
      st.ea == {st.bank_select_register, st.instr[7:0]})
    else $error("banked address wrong");

  chk_index_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.phase == PH_READ && !st.instr[8] && st.ext_en && st.instr[7:0] <= INDEX_LIMIT) |->
      st.ea == MEM_AW'(st.idx_base + {ACCESS_LO, st.instr[7:0]}))
    else $error("indexed address wrong");

  chk_mul_lit: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.phase == PH_PROC && st.op == OP_MUL_LIT) |->
      ##2 {st.product_high, st.product_low_byte} == 16'($past(st.wreg, 2)) * 16'($past(st.instr[7:0], 2)))
    else $error("literal product wrong");

  chk_mul_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.phase == PH_WRITE && (st.op == OP_MUL_LIT || st.op == OP_MUL_FILE)) |->
      !mem_wr.we ##1 ($stable(st.status) && $stable(st.wreg)))
    else $error("multiply disturbed flags or accumulator");

  chk_mul_file: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.phase == PH_PROC && st.op == OP_MUL_FILE) |->
      ##2 {st.product_high, st.product_low_byte} == 16'($past(st.wreg, 2)) * 16'($past(st.opnd, 2)))
    else $error("file product wrong");

  chk_negate_val: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.phase == PH_WRITE && st.op == OP_NEGATE) |->
      (mem_wr.we && mem_wr.addr == st.ea && mem_wr.data == 8'(8'h00 - st.opnd)))
    else $error("negate result wrong");

  chk_negate_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.phase == PH_WRITE && st.op == OP_NEGATE) |=>
      (st.status[FLG_Z] == ($past(st.opnd) == 8'h00) &&
       st.status[FLG_N] == $past(st.result[7]) &&
       st.status[FLG_OV] == ($past(st.opnd) == 8'h80)))
    else $error("negate flags wrong");

  chk_idle_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.phase == PH_WRITE && st.op == OP_IDLE) |->
      !mem_wr.we ##1 ($stable(st.status) && $stable({st.product_high, st.product_low_byte})))
    else $error("idle word changed state");

  chk_four_phase: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.phase == PH_DECODE) |->
      ##1 st.phase == PH_READ ##1 st.phase == PH_PROC ##1 st.phase == PH_WRITE
      ##1 st.phase == PH_IDLE)
    else $error("instruction did not take four phases");

endmodule : mmne_exec

/* File: hdl/mmne_pkg.sv */
package mmne_pkg;

  // opcode patterns, upper bits of the instruction word
  localparam logic [6:0] OPC_STORE    = 7'h37;  // 0110 111a
  localparam logic [6:0] OPC_NEGATE   = 7'h36;  // 0110 110a
  localparam logic [6:0] OPC_MUL_FILE = 7'h01;  // 0000 001a
  localparam logic [7:0] OPC_MUL_LIT  = 8'h0d;  // 0000 1101
  localparam logic [3:0] OPC_IDLE_HI  = 4'hf;   // 1111 xxxx
  localparam logic [15:0] OPC_IDLE    = 16'h0000;

  // addressing constants
  localparam int         MEM_AW       = 12;
  localparam logic [7:0] INDEX_LIMIT  = 8'h5f;  // highest offset for indexed mode
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;  // access bank low/high half boundary
  localparam logic [3:0] ACCESS_HI    = 4'hf;
  localparam logic [3:0] ACCESS_LO    = 4'h0;

  // register byte offsets
  localparam logic [7:0] REG_INSTR    = 8'h00;
  localparam logic [7:0] REG_ACCUM    = 8'h04;
  localparam logic [7:0] REG_BANKSEL  = 8'h08;
  localparam logic [7:0] REG_PROD_LO  = 8'h0c;
  localparam logic [7:0] REG_PROD_HI  = 8'h10;
  localparam logic [7:0] REG_STATUS   = 8'h14;
  localparam logic [7:0] REG_CTRL     = 8'h18;
  localparam logic [7:0] REG_IDX_BASE = 8'h1c;
  localparam logic [7:0] REG_MEM_ADDR = 8'h20;
  localparam logic [7:0] REG_MEM_DATA = 8'h24;

  // status flag positions
  localparam int FLG_C  = 0;
  localparam int FLG_HC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N  = 4;

  // control field positions and reset values
  localparam int         CTRL_EXT    = 0;
  localparam logic [4:0] STATUS_RST  = 5'h00;
  localparam logic [3:0] BANKSEL_RST = 4'h0;

  typedef enum logic [2:0] {
    PH_IDLE, PH_DECODE, PH_READ, PH_PROC, PH_WRITE
  } mmne_phase_t;

  typedef enum logic [2:0] {
    OP_IDLE, OP_STORE, OP_MUL_LIT, OP_MUL_FILE, OP_NEGATE
  } mmne_op_t;

  typedef struct packed {
    logic              we;
    logic [MEM_AW-1:0] addr;
    logic [7:0]        data;
  } mmne_mem_wr_t;

  typedef struct packed {
    mmne_phase_t       phase;
    mmne_op_t          op;
    logic [15:0]       instr;
    logic [7:0]        wreg;
    logic [3:0]        bank_select_register;
    logic [7:0]        product_low_byte;
    logic [7:0]        product_high;
    logic [4:0]        status;
    logic [4:0]        nflags;
    logic              ext_en;
    logic [MEM_AW-1:0] idx_base;
    logic [MEM_AW-1:0] mem_addr;
    logic [MEM_AW-1:0] ea;
    logic [7:0]        opnd;
    logic [15:0]       result;
    logic              ack;
    logic [31:0]       dat;
    logic              busy;
  } mmne_state_t;

endpackage : mmne_pkg

/* File: hdl/mmne_data_mem.sv */
`timescale 1ns/1ps

module mmne_data_mem
  import mmne_pkg::*;
#(
  parameter int DEPTH = 4096
) (
  input  wire logic              clk_i,
  input  wire mmne_mem_wr_t      wr_i,
  input  wire logic [MEM_AW-1:0] raddr_i,
  output logic      [7:0]        rdata_o
);

  // depth must cover one bank and fit the address width
  if (DEPTH < 256 || DEPTH > (1 << MEM_AW)) begin : g_bad_depth
    $error("mmne_data_mem: DEPTH out of range");
  end

  logic [7:0] mem [DEPTH];

  // byte store, out-of-range writes dropped
  always_ff @(posedge clk_i) begin
    if (wr_i.we && int'(wr_i.addr) < DEPTH) begin
      mem[wr_i.addr] <= wr_i.data;
    end
  end

  // combinational read, out-of-range reads as zero
  always_comb begin
    rdata_o = 8'h00;
    if (int'(raddr_i) < DEPTH) begin
      rdata_o = mem[raddr_i];
    end
  end

endmodule : mmne_data_mem

/* File: tb/mmne_exec_tb.sv */
`timescale 1ns/1ps

module mmne_exec_tb
  import mmne_pkg::*;
;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        busy;
  logic [31:0] q;
  int          miscompares;
  int          n_tests;

  mmne_exec dut (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc),
    .wb_stb_i (wb_stb),
    .wb_we_i  (wb_we),
    .wb_adr_i (wb_adr),
    .wb_sel_i (wb_sel),
    .wb_dat_i (wb_wdat),
    .wb_dat_o (wb_rdat),
    .wb_ack_o (wb_ack),
    .busy_o   (busy)
  );

  // clock, 20 ns period
  always #10 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////////////
  // classic single wishbone cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= a;
    wb_wdat <= d;
    wb_sel  <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    if (wb_ack !== 1'b1) begin
      miscompares++;
      summarize();
    end
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, 4'hf, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, 4'hf, r);
  endtask : rd

  task automatic poke(input logic [11:0] a, input logic [7:0] d);
    wr(REG_MEM_ADDR, {20'h0, a});
    wr(REG_MEM_DATA, {24'h0, d});
  endtask : poke

  task automatic peek(input logic [11:0] a, output logic [31:0] r);
    wr(REG_MEM_ADDR, {20'h0, a});
    rd(REG_MEM_DATA, r);
  endtask : peek

  // run one instruction, counting the cycles that busy stands
  task automatic exec(input logic [15:0] w);
    int n;
    n = 0;
    wr(REG_INSTR, {16'h0, w});
    while (busy === 1'b1 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
    check(32'(n), 32'h4);
    // a stuck instruction ends the run here
    if (busy !== 1'b0) begin
      summarize();
    end
  endtask : exec

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  logic [7:0]  rlist [6] = '{REG_ACCUM, REG_BANKSEL, REG_PROD_LO, REG_PROD_HI,
                              REG_STATUS, REG_CTRL};
  logic [7:0]  nval  [3] = '{8'h00, 8'h80, 8'h3a};
  logic [4:0]  nflg  [3] = '{5'h07, 5'h1a, 5'h10};
  logic [15:0] sins  [8] = '{16'h6e10, 16'h6e90, 16'h6e5f, 16'h6e5f, 16'h6e60,
                              16'h6f05, 16'h6fff, 16'h6f00};
  logic        sext  [8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [11:0] sadr  [8] = '{12'h010, 12'hf90, 12'h05f, 12'h35f, 12'h060,
                              12'h205, 12'h2ff, 12'h200};
  logic [15:0] prod;

  initial begin
    clk_i = 1'b0; rst_i = 1'b1; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0;
    wb_adr = 8'h00; wb_sel = 4'h0; wb_wdat = 32'h0;
    miscompares = 0; n_tests = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped place, masked write
    foreach (rlist[i]) begin
      rd(rlist[i], q);
      check(q, 32'h0);
    end
    rd(8'h30, q);
    check(q, 32'h0);
    bus(1'b1, REG_ACCUM, 32'h55, 4'he, q);
    rd(REG_ACCUM, q);
    check(q, 32'h0);
    // negate in the banked space, flags per result
    wr(REG_BANKSEL, 32'h2);
    foreach (nval[i]) begin
      poke({4'h2, nval[i]}, nval[i]);
      exec({8'h6d, nval[i]});
      peek({4'h2, nval[i]}, q);
      check(q, {24'h0, 8'(~nval[i] + 8'h1)});
      rd(REG_STATUS, q);
      check(q, {27'h0, nflg[i]});
    end
    // store through access, indexed and banked addressing
    wr(REG_IDX_BASE, 32'h300);
    foreach (sins[i]) begin
      wr(REG_CTRL, {31'h0, sext[i]});
      wr(REG_ACCUM, 32'h30 + i);
      exec(sins[i]);
      peek(sadr[i], q);
      check(q, 32'h30 + i);
    end
    rd(REG_STATUS, q);
    check(q, 32'h10);
    // multiply by file byte, file byte kept
    poke(12'h2b5, 8'hb5);
    wr(REG_ACCUM, 32'hc4);
    exec(16'h03b5);
    prod = 16'(8'hc4) * 16'(8'hb5);
    rd(REG_PROD_HI, q);
    check(q, {24'h0, prod[15:8]});
    rd(REG_PROD_LO, q);
    check(q, {24'h0, prod[7:0]});
    peek(12'h2b5, q);
    check(q, 32'hb5);
    // multiply by literal, flags and accumulator kept
    wr(REG_ACCUM, 32'he2);
    exec(16'h0dc4);
    prod = 16'(8'he2) * 16'(8'hc4);
    rd(REG_PROD_HI, q);
    check(q, {24'h0, prod[15:8]});
    rd(REG_PROD_LO, q);
    check(q, {24'h0, prod[7:0]});
    rd(REG_ACCUM, q);
    check(q, 32'he2);
    rd(REG_STATUS, q);
    check(q, 32'h10);
    // idle words change nothing, banked byte the second word would hit
    poke(12'h26d, 8'h6d);
    exec(16'h0000);
    exec(16'hf36d);
    rd(REG_PROD_LO, q);
    check(q, {24'h0, prod[7:0]});
    rd(REG_ACCUM, q);
    check(q, 32'he2);
    rd(REG_STATUS, q);
    check(q, 32'h10);
    peek(12'h26d, q);
    check(q, 32'h6d);
    summarize();
  end

endmodule : mmne_exec_tb
